// *** acf_framing.sv ***
// Purpose: Serial command framing and conversion sequencing of the converter.
// Assumes: The serial link, chip select, shutdown and comparator are
//          asynchronous and are sampled by the 100 MHz system clock.
// Notes: One serial clock period must span several system clocks.
//        A start bit is refused while the result buffer lacks room.
//        A result bit is decided from the comparator at each falling edge.
//        Shutdown clears a held byte and leaves the parser idle.
//        Result words wait in a small buffer with valid and ready.
`timescale 1ns/1ps
`default_nettype none
`include "acf_regs.svh"

module acf_framing #(
   parameter int CONV_LIMIT_CYCLES = `ACF_CONV_LIMIT_CYCLES,
   parameter int BUF_DEPTH = 2
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic din,
   input wire logic shutdown_pin_n,
   input wire logic comp_keep,
   output logic dout,
   output logic dout_oe,
   output logic conversion_strobe_out,
   output logic conversion_strobe_oe,
   output logic [11:0] sar_trial,
   output logic sample_track,
   output logic [2:0] mux_positive,
   output logic [2:0] mux_negative,
   output logic mux_negative_is_common,
   output logic unipolar,
   output logic [1:0] power_mode,
   output logic hw_shutdown,
   output logic converting,
   output logic conversion_overtime,
   output logic result_valid,
   input wire logic result_ready,
   output logic [11:0] result_code,
   output logic [7:0] result_command
);

   // ****************************************
   // State and sampled inputs
   // ****************************************
   acf_pkg::acf_state_t s;
   acf_pkg::acf_state_t next_s;

   logic sclk_rise;
   logic sclk_fall;
   logic cs_low;
   logic din_s;
   logic shutdown_pin_n_low;
   logic keep_s;
   logic buf_in_ready;
   logic buf_out_valid;
   logic [19:0] buf_out_data;
   logic start_ok;
   logic conv_busy;
   logic decide;
   logic in_overlap;
   logic at_rest;
   logic last_cmd_bit;
   logic last_decision;
   logic track_due;

   // Only the second synchroniser stage and the delayed copy are read.
   assign sclk_rise = s.sync2[0] & ~s.sclk_prev;
   assign sclk_fall = ~s.sync2[0] & s.sclk_prev;
   assign cs_low = ~s.sync2[1];
   assign din_s = s.sync2[2];
   assign shutdown_pin_n_low = ~s.sync2[3];
   assign keep_s = s.sync2[4];

   assign conv_busy = (s.cstate == acf_pkg::ACF_C_STROBE) || (s.cstate == acf_pkg::ACF_C_BITS);
   assign decide = conv_busy;

   // ****************************************
   // Events and decodes
   // ****************************************
   // Overlap opens once result bit six is on the output pin.
   assign in_overlap = (s.cstate == acf_pkg::ACF_C_BITS) && (s.bit_idx <= `ACF_OVERLAP_IDX);
   assign at_rest = (s.cstate == acf_pkg::ACF_C_IDLE) || (s.cstate == acf_pkg::ACF_C_TAIL);
   // The counter reads six while the eighth bit is on the input.
   assign last_cmd_bit = (s.cmd_cnt == 3'h6);
   // Bit index zero marks the twelfth decision.
   assign last_decision = (s.bit_idx == 4'h0);
   // Tracking begins on the fall after the fifth command bit.
   assign track_due = (s.pstate == acf_pkg::ACF_P_SHIFT) && (s.cmd_cnt >= `ACF_TRACK_AFTER_BITS);

   // A new start is taken when idle, or once result bit six is out. The
   // buffer must also have room for every conversion still in flight.
   always_comb begin
      start_ok = 1'b0;
      if (s.pending) begin
         start_ok = 1'b0;
      end else if (in_overlap) begin
         start_ok = ~buf_out_valid;
      end else if (at_rest) begin
         start_ok = buf_in_ready;
      end
   end

   // ****************************************
   // Decoding helpers
   // ****************************************

   // Maps the select code to a channel; swap picks the partner channel.
   function automatic logic [2:0] acf_channel(input logic [2:0] sel, input logic swap);
      acf_channel = {sel[1:0], sel[2] ^ swap};
   endfunction : acf_channel

   // Bipolar results are two's complement: flip the offset-binary MSB.
   function automatic logic acf_out_bit(input logic bit_value, input logic is_msb, input logic uni);
      acf_out_bit = bit_value ^ (is_msb & ~uni);
   endfunction : acf_out_bit

   // ****************************************
   // Control byte fields
   // ****************************************
   // The held byte feeds the next conversion; the running byte sets the
   // power mode that follows it.
   logic [2:0] held_select;
   logic held_polarity;
   logic held_config;
   logic [1:0] run_power;
   logic [11:0] final_code;

   assign held_select = s.next_cmd[`ACF_CHANNEL_SELECT_MSB:`ACF_CHANNEL_SELECT_LSB];
   assign held_polarity = s.next_cmd[`ACF_POLARITY_SELECT];
   assign held_config = s.next_cmd[`ACF_INPUT_CONFIG_SELECT];
   assign run_power = {s.cmd[`ACF_POWER_MODE_HI], s.cmd[`ACF_POWER_MODE_LO]};
   // The finished code takes its last bit straight from the comparator.
   assign final_code = {acf_out_bit(s.sar[11], 1'b1, s.unipolar), s.sar[10:1], keep_s};

   // ****************************************
   // Next-state logic
   // ****************************************
   always_comb begin
      next_s = s;
      next_s.sync1 = {comp_keep, shutdown_pin_n, din, cs_n, sclk};
      next_s.sync2 = s.sync1;
      next_s.sclk_prev = s.sync2[0];
      next_s.push = 1'b0;

      // Strobe and result pins float while select is high.
      next_s.dout_oe = cs_low;
      next_s.strobe_oe = cs_low;

      // Conversion watchdog for the hold-droop limit.
      if (conv_busy) begin
         if (32'(s.timer) >= CONV_LIMIT_CYCLES) begin
            next_s.overtime = 1'b1;
         end else begin
            next_s.timer = s.timer + 16'h0001;
         end
      end

      if (shutdown_pin_n_low) begin
         // Shutdown aborts at once and leaves the parser idle.
         next_s.pstate = acf_pkg::ACF_P_IDLE;
         next_s.cmd_cnt = 3'h0;
         next_s.pending = 1'b0;
         next_s.cstate = acf_pkg::ACF_C_IDLE;
         next_s.strobe = 1'b0;
         next_s.dout = 1'b0;
         next_s.track = 1'b0;
         next_s.sar = 12'h000;
         next_s.bit_idx = `ACF_RESULT_MSB_IDX;
         next_s.timer = 16'h0000;
      end else begin
         // ****************************************
         // Command parser, rising serial edges
         // ****************************************
         if (!cs_low) begin
            // A partial byte is dropped when select rises.
            next_s.pstate = acf_pkg::ACF_P_IDLE;
            next_s.cmd_cnt = 3'h0;
            next_s.strobe = 1'b0;
         end else if (sclk_rise) begin
            unique case (s.pstate)
               acf_pkg::ACF_P_IDLE: begin
                  // Zeros are skipped; a falling select alone does nothing.
                  if (din_s && start_ok) begin
                     next_s.pstate = acf_pkg::ACF_P_SHIFT;
                     next_s.cmd_cnt = 3'h0;
                     next_s.power_mode = `ACF_NORMAL_MODE;
                  end
               end
               acf_pkg::ACF_P_SHIFT: begin
                  next_s.cmd_shift = {s.cmd_shift[5:0], din_s};
                  next_s.cmd_cnt = s.cmd_cnt + 3'h1;
                  if (last_cmd_bit) begin
                     // Eighth bit in: the start bit heads the byte.
                     next_s.next_cmd = {1'b1, s.cmd_shift[5:0], din_s};
                     next_s.pending = 1'b1;
                     next_s.pstate = acf_pkg::ACF_P_IDLE;
                  end
               end
               default: begin
                  next_s.pstate = acf_pkg::ACF_P_IDLE;
               end
            endcase
         end

         // ****************************************
         // Conversion sequencer, falling serial edges
         // ****************************************
         if (sclk_fall) begin
            if (track_due) begin
               next_s.track = 1'b1;
            end

            if (decide) begin
               // One decision per falling edge; the trial bit is kept or not.
               next_s.sar[s.bit_idx] = keep_s;
               next_s.dout = acf_out_bit(keep_s, s.bit_idx == `ACF_RESULT_MSB_IDX, s.unipolar);
               next_s.strobe = 1'b0;
               if (last_decision) begin
                  next_s.cstate = acf_pkg::ACF_C_TAIL;
                  next_s.push = 1'b1;
                  next_s.push_data = {final_code, s.cmd};
                  next_s.power_mode = run_power;
               end else begin
                  next_s.sar[s.bit_idx - 4'h1] = 1'b1;
                  next_s.bit_idx = s.bit_idx - 4'h1;
                  next_s.cstate = acf_pkg::ACF_C_BITS;
               end
            end else if (s.cstate == acf_pkg::ACF_C_TAIL) begin
               next_s.dout = 1'b0;
            end

            // The held byte starts its conversion only after the last one ends.
            if (s.pending && !conv_busy) begin
               next_s.pending = 1'b0;
               next_s.cmd = s.next_cmd;
               next_s.cstate = acf_pkg::ACF_C_STROBE;
               next_s.strobe = cs_low;
               next_s.dout = 1'b0;
               next_s.track = 1'b0;
               next_s.bit_idx = `ACF_RESULT_MSB_IDX;
               next_s.sar = 12'h800;
               next_s.timer = 16'h0000;
               next_s.overtime = 1'b0;
               next_s.power_mode = `ACF_NORMAL_MODE;
               next_s.unipolar = held_polarity;
               next_s.mux_pos = acf_channel(held_select, 1'b0);
               next_s.mux_neg = acf_channel(held_select, 1'b1);
               next_s.neg_com = held_config;
            end
         end
      end
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         s <= '0;
         // Synchronisers wake up as if select were high and shutdown released.
         s.sync1 <= `ACF_SYNC_RESET;
         s.sync2 <= `ACF_SYNC_RESET;
         s.pstate <= acf_pkg::ACF_P_IDLE;
         s.cstate <= acf_pkg::ACF_C_IDLE;
         s.power_mode <= `ACF_NORMAL_MODE;
         s.neg_com <= 1'b1;
         s.unipolar <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // ****************************************
   // Result buffer
   // ****************************************
   // Finished words wait here until the consumer takes them.
   acf_pair_buffer #(
      .WIDTH(20),
      .DEPTH(BUF_DEPTH)
   ) u_result_buffer (
      .clock(clock),
      .resetn(resetn),
      .in_valid(s.push),
      .in_ready(buf_in_ready),
      .in_data(s.push_data),
      .out_valid(buf_out_valid),
      .out_ready(result_ready),
      .out_data(buf_out_data)
   );

   // ****************************************
   // Outputs
   // ****************************************
   // Link pins and their enables.
   assign dout = s.dout;
   assign dout_oe = s.dout_oe;
   assign conversion_strobe_out = s.strobe;
   assign conversion_strobe_oe = s.strobe_oe;

   // Analog front-end controls.
   assign sar_trial = s.sar;
   assign sample_track = s.track;
   assign mux_positive = s.mux_pos;
   assign mux_negative = s.mux_neg;
   assign mux_negative_is_common = s.neg_com;
   assign unipolar = s.unipolar;
   assign power_mode = s.power_mode;

   // Status and the result stream.
   assign hw_shutdown = shutdown_pin_n_low;
   assign converting = conv_busy;
   assign conversion_overtime = s.overtime;
   assign result_valid = buf_out_valid;
   assign result_code = buf_out_data[19:8];
   assign result_command = buf_out_data[7:0];

endmodule : acf_framing

`default_nettype wire

// *** acf_regs.svh ***
// Purpose: Constants of the serial command framing block of the converter.
// Assumes: A 100 MHz system clock samples the serial link.
// Notes: Bit positions refer to the 8-bit control byte.
`ifndef ACF_REGS_SVH
`define ACF_REGS_SVH

// ****************************************
// Control byte layout
// ****************************************
`define ACF_CMD_BITS 8
`define ACF_START_BIT 7
`define ACF_CHANNEL_SELECT_MSB 6
`define ACF_CHANNEL_SELECT_LSB 4
`define ACF_POLARITY_SELECT 3
`define ACF_INPUT_CONFIG_SELECT 2
`define ACF_POWER_MODE_HI 1
`define ACF_POWER_MODE_LO 0
`define ACF_TRACK_AFTER_BITS 3'h4

// ****************************************
// Conversion and power
// ****************************************
`define ACF_RESULT_BITS 12
`define ACF_OVERLAP_IDX 4'h5
`define ACF_RESULT_MSB_IDX 4'hB
`define ACF_MIN_CLOCKS_PER_CONV 16
`define ACF_DEEP_SLEEP_MODE 2'h0
`define ACF_QUICK_SLEEP_MODE 2'h1
`define ACF_LOW_CURRENT_MODE 2'h2
`define ACF_NORMAL_MODE 2'h3
`define ACF_SYNC_RESET 5'h0A

// ****************************************
// Timing
// ****************************************
`define ACF_CLOCK_MHZ 100
`define ACF_CONV_LIMIT_US 120
`define ACF_CONV_LIMIT_CYCLES (`ACF_CONV_LIMIT_US * `ACF_CLOCK_MHZ)

`endif

// *** acf_pkg.sv ***
// Purpose: Types of the serial command framing block.
// Assumes: Constants come from acf_regs.svh.
// Notes: The state record is shared by the framing module only.
package acf_pkg;

   typedef enum logic [1:0] {
      ACF_P_IDLE = 2'b01,
      ACF_P_SHIFT = 2'b10
   } acf_parse_t;

   typedef enum logic [3:0] {
      ACF_C_IDLE = 4'b0001,
      ACF_C_STROBE = 4'b0010,
      ACF_C_BITS = 4'b0100,
      ACF_C_TAIL = 4'b1000
   } acf_conv_t;

   typedef struct packed {
      logic [4:0] sync1;
      logic [4:0] sync2;
      logic sclk_prev;
      acf_parse_t pstate;
      logic [6:0] cmd_shift;
      logic [2:0] cmd_cnt;
      logic pending;
      logic [7:0] next_cmd;
      logic [7:0] cmd;
      acf_conv_t cstate;
      logic [3:0] bit_idx;
      logic [11:0] sar;
      logic dout;
      logic dout_oe;
      logic strobe;
      logic strobe_oe;
      logic track;
      logic [2:0] mux_pos;
      logic [2:0] mux_neg;
      logic neg_com;
      logic unipolar;
      logic [1:0] power_mode;
      logic [15:0] timer;
      logic overtime;
      logic push;
      logic [19:0] push_data;
   } acf_state_t;

endpackage : acf_pkg

// *** acf_pair_buffer.sv ***
// Purpose: Small valid/ready buffer for finished conversion results.
// Assumes: Both sides run on the system clock.
// Notes: in_ready drops when every entry holds a word.
`timescale 1ns/1ps
`default_nettype none

module acf_pair_buffer #(
   parameter int WIDTH = 20,
   parameter int DEPTH = 2
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);

   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0] wr_ptr;
      logic [PW-1:0] rd_ptr;
      logic [PW:0] count;
   } acf_buf_state_t;

   acf_buf_state_t s;
   acf_buf_state_t next_s;

   logic do_write;
   logic do_read;

   assign in_ready = (s.count != (PW+1)'(DEPTH));
   assign out_valid = (s.count != '0);
   assign out_data = s.mem[s.rd_ptr];
   assign do_write = in_valid & in_ready;
   assign do_read = out_valid & out_ready;

   function automatic logic [PW-1:0] acf_bump(input logic [PW-1:0] ptr);
      acf_bump = (ptr == (PW)'(DEPTH - 1)) ? '0 : ptr + 1'b1;
   endfunction : acf_bump

   always_comb begin
      next_s = s;
      if (do_write) begin
         next_s.mem[s.wr_ptr] = in_data;
         next_s.wr_ptr = acf_bump(s.wr_ptr);
      end
      if (do_read) begin
         next_s.rd_ptr = acf_bump(s.rd_ptr);
      end
      if (do_write && !do_read) begin
         next_s.count = s.count + 1'b1;
      end else if (do_read && !do_write) begin
         next_s.count = s.count - 1'b1;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

endmodule : acf_pair_buffer

`default_nettype wire

// *** acf_framing_properties.sv ***
// Purpose: Concurrent checks on the ports of the serial command framing block.
// Assumes: One system clock domain with an asynchronous active-low reset.
// Notes: Bound to every instance of the framing block.
`timescale 1ns/1ps
`default_nettype none

module acf_framing_properties (
   input wire logic clock,
   input wire logic resetn,
   input wire logic cs_n,
   input wire logic shutdown_pin_n,
   input wire logic dout_oe,
   input wire logic conversion_strobe_out,
   input wire logic conversion_strobe_oe,
   input wire logic [11:0] sar_trial,
   input wire logic [2:0] mux_positive,
   input wire logic [2:0] mux_negative,
   input wire logic mux_negative_is_common,
   input wire logic [1:0] power_mode,
   input wire logic hw_shutdown,
   input wire logic converting,
   input wire logic result_valid,
   input wire logic result_ready,
   input wire logic [11:0] result_code,
   input wire logic [7:0] result_command
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!resetn);

   // ****************************************
   // Link outputs
   // ****************************************
   AST_OE_PAIR: assert property (dout_oe == conversion_strobe_oe)
      else $error("output enables differ");
   AST_FLOAT_ON_CS: assert property (cs_n [*4] |-> !dout_oe && !conversion_strobe_out)
      else $error("outputs driven with select high");
   AST_STROBE_STARTS: assert property ($rose(conversion_strobe_out) |-> converting && sar_trial == 12'h800)
      else $error("strobe without conversion start");
   AST_CONV_HAS_STROBE: assert property ($rose(converting) && conversion_strobe_oe |-> conversion_strobe_out)
      else $error("conversion started without strobe");
   AST_FIRST_STEP: assert property ($fell(conversion_strobe_out) && converting && conversion_strobe_oe
      |-> sar_trial[10] && sar_trial[9:0] == 10'h000)
      else $error("first step after strobe wrong");

   // ****************************************
   // Shutdown, power and channels
   // ****************************************
   AST_SHUTDOWN_PIN_N_SYNC: assert property (!shutdown_pin_n [*4] |-> hw_shutdown)
      else $error("shutdown not seen");
   AST_SHUTDOWN_PIN_N_ABORT: assert property (hw_shutdown |=> !converting)
      else $error("conversion runs in shutdown");
   AST_FULL_POWER: assert property (converting |-> power_mode == 2'h3)
      else $error("low power mode while converting");
   AST_PAIR_SWAP: assert property (converting && !mux_negative_is_common |-> mux_negative == (mux_positive ^ 3'h1))
      else $error("pair inputs not partners");

   // ****************************************
   // Result buffer
   // ****************************************
   AST_HEAD_HOLDS: assert property (result_valid && !result_ready |=> result_valid && $stable(result_code) && $stable(result_command))
      else $error("stalled result changed");
   AST_CMD_START: assert property (result_valid |-> result_command[7])
      else $error("stored command lacks start bit");

   COV_STROBE: cover property ($rose(conversion_strobe_out));
   COV_STALL: cover property (result_valid && !result_ready ##1 result_valid);
   COV_ABORT: cover property ($fell(converting) && hw_shutdown);
endmodule : acf_framing_properties

bind acf_framing acf_framing_properties chk (.clock, .resetn, .cs_n, .shutdown_pin_n, .dout_oe,
   .conversion_strobe_out, .conversion_strobe_oe, .sar_trial, .mux_positive, .mux_negative,
   .mux_negative_is_common, .power_mode, .hw_shutdown, .converting, .result_valid, .result_ready,
   .result_code, .result_command);

`default_nettype wire

// *** acf_serial_master.sv ***
// Purpose: Clocked serial master that drives the converter's link.
// Assumes: Serial clock period of 80 ns, idle low.
// Notes: The serial clock stands still outside transfers.
`timescale 1ns/1ps
`default_nettype none

module acf_serial_master (
   output var logic sclk,
   output var logic cs_n,
   output var logic din,
   input wire logic dout
);
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      din = 1'b0;
   end

   task automatic select(input logic level);
      cs_n = level;
      #80;
   endtask : select

   // Bits leave MSB first; din changes only while the clock is low.
   task automatic shift(input logic [63:0] tx, input int n, output logic [63:0] rx);
      rx = '0;
      for (int i = n - 1; i >= 0; i--) begin
         din = tx[i];
         #40 sclk = 1'b1;
         #38 rx = {rx[62:0], dout};
         #2 sclk = 1'b0;
      end
   endtask : shift
endmodule : acf_serial_master

`default_nettype wire

// *** acf_framing_bench.sv ***
// Purpose: Self-checking bench of the serial command framing block.
// Assumes: 100 MHz system clock, serial master at 80 ns per bit.
// Notes: The comparator is modelled against a fixed analog target code.
`timescale 1ns/1ps
`default_nettype none

module acf_framing_bench;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic shutdown_pin_n = 1'b1;
   logic result_ready = 1'b0;
   logic [11:0] target = 12'h000;
   int mismatches = 0;
   int check_count = 0;
   wire logic sclk, cs_n, din, dout, comp_keep;
   wire logic [11:0] sar_trial, result_code;
   wire logic [2:0] mux_positive, mux_negative;
   wire logic mux_negative_is_common, unipolar, hw_shutdown, converting, result_valid;
   wire logic [1:0] power_mode;
   wire logic [7:0] result_command;
   wire logic dout_oe, dout_pin, sample_track, conversion_overtime;

   assign comp_keep = (target >= sar_trial);
   // A floating result pin shows the inverse of the last bit.
   assign dout_pin = dout_oe ? dout : ~dout;

   acf_serial_master m (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout_pin));

   acf_framing #(.CONV_LIMIT_CYCLES(200)) dut (.clock(clock), .resetn(resetn), .sclk(sclk), .cs_n(cs_n), .din(din),
      .shutdown_pin_n(shutdown_pin_n), .comp_keep(comp_keep), .dout(dout), .dout_oe(dout_oe),
      .conversion_strobe_out(), .conversion_strobe_oe(), .sar_trial(sar_trial), .sample_track(sample_track),
      .mux_positive(mux_positive), .mux_negative(mux_negative),
      .mux_negative_is_common(mux_negative_is_common), .unipolar(unipolar), .power_mode(power_mode),
      .hw_shutdown(hw_shutdown), .converting(converting), .conversion_overtime(conversion_overtime),
      .result_valid(result_valid), .result_ready(result_ready), .result_code(result_code),
      .result_command(result_command));

   initial begin
      forever #5 clock = ~clock;
   end

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : finish_test

   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
      end
   endtask : check

   task automatic tick();
      @(posedge clock);
      #1;
   endtask : tick

   task automatic wait_valid();
      int n;
      n = 0;
      while (result_valid !== 1'b1 && n < 300) begin
         tick();
         n++;
      end
      if (n == 300) begin
         check("result_valid", 1, 0);
         finish_test();
      end
   endtask : wait_valid

   task automatic take();
      result_ready = 1'b1;
      tick();
      result_ready = 1'b0;
   endtask : take

   task automatic frame(input logic [63:0] tx, input int n, output logic [63:0] rx);
      tick();
      m.select(1'b0);
      m.shift(tx, n, rx);
      m.select(1'b1);
      repeat (6) tick();
   endtask : frame

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic test_channels();
      logic [63:0] rx;
      logic [7:0] cmd;
      logic [11:0] exp;
      for (int k = 0; k < 16; k++) begin
         cmd = {1'b1, k[2:0], k[0] ^ k[3], k[3], k[1:0]};
         target = 12'h137 * k[3:0] + 12'h0A5;
         exp = cmd[3] ? target : (target ^ 12'h800);
         frame({36'h0, 4'h0, cmd, 16'h0}, 28, rx);
         check("dout stream", {exp, 3'h0}, rx[14:0]);
         check("mux_positive", {cmd[5:4], cmd[6]}, mux_positive);
         check("negative is common", cmd[2], mux_negative_is_common);
         if (!cmd[2])
            check("mux_negative", {cmd[5:4], ~cmd[6]}, mux_negative);
         check("unipolar", cmd[3], unipolar);
         check("power_mode", cmd[1:0], power_mode);
         check("overtime", 0, conversion_overtime);
         wait_valid();
         check("result_code", exp, result_code);
         check("result_command", cmd, result_command);
         take();
      end
      $display("test_channels done");
   endtask : test_channels

   // The one in the gap arrives before result bit 6 and must be ignored.
   task automatic test_back_to_back();
      logic [63:0] rx;
      target = 12'h3C5;
      result_ready = 1'b1;
      frame({24'h0, 8'hFD, 8'h10, 8'hA3, 16'h0}, 40, rx);
      check("first result", target, rx[30:19]);
      check("second result", {target ^ 12'h800, 3'h0}, rx[14:0]);
      repeat (4) tick();
      result_ready = 1'b0;
      $display("test_back_to_back done");
   endtask : test_back_to_back

   task automatic test_buffer_full();
      logic [63:0] rx;
      for (int j = 0; j < 3; j++) begin
         target = 12'h111 * j[3:0] + 12'h111;
         frame({36'h0, 4'h0, 1'b1, j[2:0], 4'hF, 16'h0}, 28, rx);
      end
      check("refused stream", 0, rx[14:0]);
      wait_valid();
      check("first word", 12'h111, result_code);
      check("first command", 8'h8F, result_command);
      take();
      check("second word", 12'h222, result_code);
      check("second command", 8'h9F, result_command);
      take();
      check("buffer empty", 0, result_valid);
      $display("test_buffer_full done");
   endtask : test_buffer_full

   task automatic test_shutdown();
      logic [63:0] rx;
      tick();
      m.select(1'b0);
      m.shift(64'h7F, 7, rx);
      repeat (4) tick();
      check("sample_track", 1, sample_track);
      m.shift(64'h40, 7, rx);
      repeat (200) tick();
      check("overtime", 1, conversion_overtime);
      shutdown_pin_n = 1'b0;
      repeat (6) tick();
      check("hw_shutdown", 1, hw_shutdown);
      check("converting", 0, converting);
      shutdown_pin_n = 1'b1;
      repeat (6) tick();
      m.shift(64'h0, 24, rx);
      m.select(1'b1);
      repeat (20) tick();
      check("aborted result", 0, result_valid);
      target = 12'hABC;
      frame({36'h0, 4'h0, 8'hFF, 16'h0}, 28, rx);
      check("fresh stream", {12'hABC, 3'h0}, rx[14:0]);
      wait_valid();
      take();
      $display("test_shutdown done");
   endtask : test_shutdown

   initial begin
      repeat (2) @(posedge clock);
      #1;
      check("reset power_mode", 3, power_mode);
      check("reset common", 1, mux_negative_is_common);
      check("reset oe", 0, dout_oe);
      check("reset valid", 0, result_valid);
      repeat (2) @(posedge clock);
      #1;
      resetn = 1'b1;
      repeat (5) tick();
      test_channels();
      test_back_to_back();
      test_buffer_full();
      test_shutdown();
      finish_test();
   end
endmodule : acf_framing_bench

`default_nettype wire
